// ==== hw/cspc_consts.vh ====
// Purpose: constants for the clock switch and power save controller
// Assumes: one clock (mclk, 50 MHz), register port with 2-bit index
// Notes: register index, field, source, enable and timing defines follow
`ifndef CSPC_CONSTS_VH
`define CSPC_CONSTS_VH

// Register indices
`define CSPC_REG_OSC      2'h0
`define CSPC_REG_PWR      2'h1

// Control register fields
`define CSPC_F_CURRENT_SOURCE_STATUS_HI    14
`define CSPC_F_CURRENT_SOURCE_STATUS_LO    12
`define CSPC_F_NEW_SOURCE_SELECT_HI    10
`define CSPC_F_NEW_SOURCE_SELECT_LO    8
`define CSPC_F_LOCK       5
`define CSPC_F_CF         3
`define CSPC_F_SOSCEN     1
`define CSPC_F_SWREQ      0

// Source codes
`define CSPC_SRC_FRC      3'h0
`define CSPC_SRC_FRCPLL   3'h1
`define CSPC_SRC_PRI      3'h2
`define CSPC_SRC_PRIPLL   3'h3
`define CSPC_SRC_SOSC     3'h4
`define CSPC_SRC_LOW_POWER_RC_OSC     3'h5

// Primary submodes
`define CSPC_SUB_EC       2'h0
`define CSPC_SUB_XT       2'h1
`define CSPC_SUB_HS       2'h2

// Oscillator enable bit positions
`define CSPC_EN_FRC       0
`define CSPC_EN_PRI       1
`define CSPC_EN_SOSC      2
`define CSPC_EN_LOW_POWER_RC_OSC      3
`define CSPC_EN_PLL       4

// Timing
`define CSPC_CLK_NS       20
`define CSPC_OST_CYC      1024
`define CSPC_HANDOVER_CYC 10
`define CSPC_RESUME_CYC   3

`endif

// ==== hw/cspc_sync3.v ====
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: d comes from outside the mclk domain
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cspc_sync3 (
  input  wire mclk,
  input  wire nrst,
  input  wire d,
  output reg  q_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Stage chain, first stage feeds only the second
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r  <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end
endmodule // cspc_sync3
`default_nettype wire

// ==== hw/cspc_dcnt.v ====
// Purpose: loadable down counter with zero flag
// Assumes: load has priority over decrement
// Notes: holds at zero
`timescale 1ns/1ps
`default_nettype none
module cspc_dcnt #(
  parameter W = 11
) (
  input  wire         mclk,
  input  wire         nrst,
  input  wire         load,
  input  wire [W-1:0] ld_val,
  input  wire         dec,
  output wire         zero
);
  reg [W-1:0] cnt_r;

  // Count down to zero
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= ld_val;
    end else if (dec && (cnt_r != {W{1'b0}})) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign zero = (cnt_r == {W{1'b0}});
endmodule // cspc_dcnt
`default_nettype wire

// ==== hw/cspc_top.v ====
// Purpose: oscillator switching, fail-safe monitor and Sleep/Idle control
// Assumes: config inputs static after reset; oscillator clocks seen as pins
// Notes: registers over a plain strobe port, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "cspc_consts.vh"
module cspc_top #(
  parameter OST_CYC  = `CSPC_OST_CYC,
  parameter HAND_CYC = `CSPC_HANDOVER_CYC,
  parameter RES_CYC  = `CSPC_RESUME_CYC
) (
  input  wire        mclk,
  input  wire        nrst,
  input  wire [1:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire [1:0]  reg_wbe,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        unlock,
  input  wire        switch_monitor_cfg_bit,
  input  wire [2:0]  reset_source_cfg,
  input  wire [1:0]  primary_submode_cfg,
  input  wire        watchdog_en,
  input  wire        watchdog_timeout,
  input  wire        irq_wake,
  input  wire        ps_req,
  input  wire        ps_sleep,
  input  wire        pll_lock_pin,
  input  wire        target_clk_pin,
  input  wire        osc_fail_pin,
  output reg  [4:0]  osc_en_r,
  output reg  [2:0]  sys_src_r,
  output reg  [2:0]  target_src_r,
  output reg  [1:0]  primary_submode_r,
  output reg         sys_clk_en_r,
  output reg         cpu_clk_en_r,
  output reg         cpu_resume_r,
  output reg         watchdog_clr_r,
  output reg         clk_fail_trap_r
);
  // Switch states
  localparam [3:0] SW_IDLE  = 4'b0001;
  localparam [3:0] SW_CHECK = 4'b0010;
  localparam [3:0] SW_WAIT  = 4'b0100;
  localparam [3:0] SW_CNT   = 4'b1000;
  // Power states
  localparam [3:0] PS_RUN   = 4'b0001;
  localparam [3:0] PS_IDLE  = 4'b0010;
  localparam [3:0] PS_SLEEP = 4'b0100;
  localparam [3:0] PS_WAKE  = 4'b1000;

  localparam [10:0] OST_LD  = OST_CYC[10:0];
  localparam [3:0]  HAND_LD = HAND_CYC[3:0];
  localparam [2:0]  RES_LD  = RES_CYC[2:0];

  reg  [3:0] sw_st_r;
  reg  [3:0] sw_st_nxt;
  reg  [3:0] ps_st_r;
  reg  [3:0] ps_st_nxt;
  reg  [2:0] current_source_status_r;
  reg  [2:0] new_source_select_r;
  reg        swreq_r;
  reg        lock_r;
  reg        cf_r;
  reg        soscen_r;
  reg        unlk_r;
  reg        init_r;
  reg        tclk_d_r;
  reg        fail_d_r;
  reg        need_ost_r;
  wire       lock_s;
  wire       tclk_s;
  wire       fail_s;
  wire       ost_zero;
  wire       hand_zero;
  wire       res_zero;

  // Switching allowed only with the config bit programmed to 0
  wire sw_en    = ~switch_monitor_cfg_bit;
  // Monitor runs with switching enabled, never in Sleep
  wire fail_safe_monitor_on  = sw_en & (ps_st_r != PS_SLEEP);
  wire in_sleep = (ps_st_r == PS_SLEEP);
  wire wr_osc   = reg_wr & (reg_addr == `CSPC_REG_OSC) & unlk_r;
  wire wr_hi    = wr_osc & reg_wbe[1];
  wire wr_lo    = wr_osc & reg_wbe[0];
  wire tclk_rise = tclk_s & ~tclk_d_r;
  wire fail_ev  = fail_safe_monitor_on & fail_s & ~fail_d_r;
  wire start_sw = (sw_st_r == SW_CHECK) & (current_source_status_r != new_source_select_r);
  wire wake     = irq_wake | watchdog_timeout;

  // Oscillators each source needs
  function [4:0] src_need;
    input [2:0] s;
    begin
      src_need = 5'h00;
      case (s)
        `CSPC_SRC_FRCPLL: src_need = 5'h11;
        `CSPC_SRC_PRI:    src_need = 5'h02;
        `CSPC_SRC_PRIPLL: src_need = 5'h12;
        `CSPC_SRC_SOSC:   src_need = 5'h04;
        `CSPC_SRC_LOW_POWER_RC_OSC:   src_need = 5'h08;
        default:          src_need = 5'h01;
      endcase
    end
  endfunction

  function uses_pll;
    input [2:0] s;
    begin
      uses_pll = (s == `CSPC_SRC_FRCPLL) | (s == `CSPC_SRC_PRIPLL);
    end
  endfunction

  function is_pri;
    input [2:0] s;
    begin
      is_pri = (s == `CSPC_SRC_PRI) | (s == `CSPC_SRC_PRIPLL);
    end
  endfunction

  // Crystal submodes need the start-up timer, external clock does not
  wire xtal = (primary_submode_cfg == `CSPC_SUB_XT) |
              (primary_submode_cfg == `CSPC_SUB_HS);

  // Pin synchronisers
  cspc_sync3 u_sync_lock (
    .mclk (mclk),
    .nrst (nrst),
    .d    (pll_lock_pin),
    .q_r  (lock_s)
  );
  cspc_sync3 u_sync_tclk (
    .mclk (mclk),
    .nrst (nrst),
    .d    (target_clk_pin),
    .q_r  (tclk_s)
  );
  cspc_sync3 u_sync_fail (
    .mclk (mclk),
    .nrst (nrst),
    .d    (osc_fail_pin),
    .q_r  (fail_s)
  );

  // Oscillator start-up timer, loaded when a valid switch starts
  cspc_dcnt #(.W(11)) u_ost (
    .mclk   (mclk),
    .nrst   (nrst),
    .load   (start_sw),
    .ld_val (OST_LD),
    .dec    (sw_st_r == SW_WAIT),
    .zero   (ost_zero)
  );
  // Target clock cycles before changeover
  cspc_dcnt #(.W(4)) u_hand (
    .mclk   (mclk),
    .nrst   (nrst),
    .load   (sw_st_r != SW_CNT),
    .ld_val (HAND_LD),
    .dec    (tclk_rise),
    .zero   (hand_zero)
  );
  // Delay from wake to CPU resume
  cspc_dcnt #(.W(3)) u_res (
    .mclk   (mclk),
    .nrst   (nrst),
    .load   (ps_st_r != PS_WAKE),
    .ld_val (RES_LD),
    .dec    (1'b1),
    .zero   (res_zero)
  );

  // Target ready: start-up timer for crystal, lock for PLL
  wire ost_ok  = ~need_ost_r | ost_zero;
  wire pll_ok  = ~uses_pll(new_source_select_r) | lock_s;
  wire tgt_rdy = ost_ok & pll_ok;

  // Switch sequencer next state
  always @* begin
    sw_st_nxt = sw_st_r;
    case (sw_st_r)
      SW_IDLE: begin
        if (swreq_r && sw_en) begin
          sw_st_nxt = SW_CHECK;
        end
      end
      SW_CHECK: begin
        if (current_source_status_r == new_source_select_r) begin
          sw_st_nxt = SW_IDLE;
        end else begin
          sw_st_nxt = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (tgt_rdy) begin
          sw_st_nxt = SW_CNT;
        end
      end
      SW_CNT: begin
        if (hand_zero) begin
          sw_st_nxt = SW_IDLE;
        end
      end
      default: sw_st_nxt = SW_IDLE;
    endcase
    if (fail_ev) begin
      sw_st_nxt = SW_IDLE;
    end
  end

  // Power-save next state
  always @* begin
    ps_st_nxt = ps_st_r;
    case (ps_st_r)
      PS_RUN: begin
        if (ps_req) begin
          ps_st_nxt = ps_sleep ? PS_SLEEP : PS_IDLE;
        end
      end
      PS_IDLE: begin
        if (wake) begin
          ps_st_nxt = PS_WAKE;
        end
      end
      PS_SLEEP: begin
        if (wake) begin
          ps_st_nxt = PS_WAKE;
        end
      end
      PS_WAKE: begin
        if (res_zero) begin
          ps_st_nxt = PS_RUN;
        end
      end
      default: ps_st_nxt = PS_RUN;
    endcase
  end

  // State registers and edge history
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sw_st_r  <= SW_IDLE;
      ps_st_r  <= PS_RUN;
      tclk_d_r <= 1'b0;
      fail_d_r <= 1'b0;
    end else begin
      sw_st_r  <= sw_st_nxt;
      ps_st_r  <= ps_st_nxt;
      tclk_d_r <= tclk_s;
      fail_d_r <= fail_s;
    end
  end

  // Unlock arms exactly one control register write
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      unlk_r <= 1'b0;
    end else if (unlock) begin
      unlk_r <= 1'b1;
    end else if (reg_wr && (reg_addr == `CSPC_REG_OSC)) begin
      unlk_r <= 1'b0;
    end
  end

  // Source fields, request, fail flag
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      init_r     <= 1'b1;
      current_source_status_r     <= `CSPC_SRC_FRC;
      new_source_select_r     <= `CSPC_SRC_FRC;
      swreq_r    <= 1'b0;
      cf_r       <= 1'b0;
      soscen_r   <= 1'b0;
      need_ost_r <= 1'b0;
    end else begin
      init_r <= 1'b0;
      // Reset-time source caught after release
      if (init_r || !sw_en) begin
        current_source_status_r <= reset_source_cfg;
      end
      if (init_r) begin
        new_source_select_r <= reset_source_cfg;
      end else if (wr_hi) begin
        new_source_select_r <= reg_wdata[`CSPC_F_NEW_SOURCE_SELECT_HI:`CSPC_F_NEW_SOURCE_SELECT_LO];
      end
      if (wr_lo) begin
        soscen_r <= reg_wdata[`CSPC_F_SOSCEN];
      end
      // Request bit: ignored and zero while switching is off
      if (!sw_en) begin
        swreq_r <= 1'b0;
      end else if (fail_ev) begin
        swreq_r <= 1'b0;
      end else if (sw_st_r == SW_CHECK && current_source_status_r == new_source_select_r) begin
        swreq_r <= 1'b0;
      end else if (sw_st_r == SW_CNT && hand_zero) begin
        swreq_r <= 1'b0;
        current_source_status_r  <= new_source_select_r;
      end else if (wr_lo && reg_wdata[`CSPC_F_SWREQ]) begin
        swreq_r <= 1'b1;
      end
      // Crystal start needed only if primary not yet running
      if (start_sw) begin
        need_ost_r <= is_pri(new_source_select_r) & xtal & ~osc_en_r[`CSPC_EN_PRI];
      end
      // Monitor fallback keeps PLL factor when PLL was in use
      if (fail_ev) begin
        current_source_status_r <= uses_pll(current_source_status_r) ? `CSPC_SRC_FRCPLL : `CSPC_SRC_FRC;
      end
      // Fail flag: failure beats clear
      if (fail_ev) begin
        cf_r <= 1'b1;
      end else if (start_sw) begin
        cf_r <= 1'b0;
      end else if (wr_lo && !reg_wdata[`CSPC_F_CF]) begin
        cf_r <= 1'b0;
      end
    end
  end

  // Oscillator enables for current, target and kept-alive sources
  wire switching = (sw_st_r == SW_WAIT) | (sw_st_r == SW_CNT);
  wire [4:0] run_need = src_need(current_source_status_r) | (switching ? src_need(new_source_select_r) : 5'h00);
  wire keep_low_power_rc_osc = in_sleep ? watchdog_en : (watchdog_en | fail_safe_monitor_on);
  wire [4:0] keep = {1'b0, keep_low_power_rc_osc, soscen_r, 2'b00};
  wire [4:0] en_nxt = (in_sleep ? 5'h00 : run_need) | keep;

  // Output and status registers
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc_en_r          <= 5'h01;
      sys_src_r         <= `CSPC_SRC_FRC;
      target_src_r      <= `CSPC_SRC_FRC;
      primary_submode_r <= `CSPC_SUB_EC;
      sys_clk_en_r      <= 1'b1;
      cpu_clk_en_r      <= 1'b1;
      cpu_resume_r      <= 1'b0;
      watchdog_clr_r    <= 1'b0;
      clk_fail_trap_r   <= 1'b0;
      lock_r            <= 1'b0;
    end else begin
      osc_en_r          <= en_nxt;
      sys_src_r         <= current_source_status_r;
      target_src_r      <= new_source_select_r;
      primary_submode_r <= primary_submode_cfg;
      // Sleep gates the system clock, Idle only the CPU
      sys_clk_en_r      <= (ps_st_nxt != PS_SLEEP);
      cpu_clk_en_r      <= (ps_st_nxt == PS_RUN);
      cpu_resume_r      <= (ps_st_r == PS_WAKE) & res_zero;
      watchdog_clr_r    <= (ps_st_r == PS_RUN) & ps_req & watchdog_en;
      clk_fail_trap_r   <= fail_ev;
      if (start_sw) begin
        lock_r <= 1'b0;
      end else begin
        lock_r <= en_nxt[`CSPC_EN_PLL] & osc_en_r[`CSPC_EN_PLL] & lock_s;
      end
    end
  end

  // Power and switch status word
  wire [15:0] pwr_stat = {11'h000, fail_safe_monitor_on, switching | (sw_st_r == SW_CHECK),
                          ps_st_r == PS_WAKE, ps_st_r == PS_IDLE, in_sleep};

  // Read data one cycle after the strobe, zero elsewhere
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CSPC_REG_OSC: reg_rdata <= {1'b0, current_source_status_r, 1'b0, new_source_select_r, 2'b00, lock_r,
                                     1'b0, cf_r, 1'b0, soscen_r, swreq_r & sw_en};
        `CSPC_REG_PWR: reg_rdata <= pwr_stat;
        default:       reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // cspc_top
`default_nettype wire

// ==== sim/cspc_checker.sv ====
// Purpose: port-level checks of the clock switch and power save controller
// Assumes: config inputs change only while reset is held
// Notes: bound to the top module after the module body
`timescale 1ns/1ps
`default_nettype none
module cspc_checker #(
  parameter OST_CYC  = 1024,
  parameter HAND_CYC = 10,
  parameter RES_CYC  = 3
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [1:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        switch_monitor_cfg_bit,
  input wire logic [2:0]  reset_source_cfg,
  input wire logic [1:0]  primary_submode_cfg,
  input wire logic        watchdog_en,
  input wire logic        watchdog_timeout,
  input wire logic        irq_wake,
  input wire logic        ps_req,
  input wire logic        ps_sleep,
  input wire logic [4:0]  osc_en_r,
  input wire logic [2:0]  sys_src_r,
  input wire logic [1:0]  primary_submode_r,
  input wire logic        sys_clk_en_r,
  input wire logic        cpu_clk_en_r,
  input wire logic        cpu_resume_r,
  input wire logic        watchdog_clr_r,
  input wire logic        clk_fail_trap_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Switching disabled by config, submode follows config, failure fallback
  swreq_off_a: assert property (switch_monitor_cfg_bit && reg_rd && reg_addr == 2'h0
    |=> !reg_rdata[0]) else $error("request bit read as one while switching is off");
  src_cfg_a: assert property (switch_monitor_cfg_bit
    |-> ##3 sys_src_r == $past(reset_source_cfg, 3)) else $error("source differs from config");
  trap_off_a: assert property (switch_monitor_cfg_bit |-> !clk_fail_trap_r)
    else $error("failure trap while monitor is off");
  submode_fix_a: assert property (1'b1 |-> ##2 primary_submode_r == $past(primary_submode_cfg, 2))
    else $error("primary submode differs from config");
  fail_src_a: assert property (clk_fail_trap_r |-> ##[0:1] sys_src_r[2:1] == 2'b00)
    else $error("failure did not fall back to fast RC");

  // Power save entry and wake
  sleep_gate_a: assert property (ps_req && ps_sleep && cpu_clk_en_r && sys_clk_en_r
    |-> ##[1:2] !cpu_clk_en_r && !sys_clk_en_r) else $error("sleep did not stop clocks");
  wdog_clr_a: assert property (ps_req && cpu_clk_en_r && watchdog_en
    |-> ##[1:2] watchdog_clr_r) else $error("watchdog not cleared on entry");
  wake_resume_a: assert property ($rose(irq_wake || watchdog_timeout) && !cpu_clk_en_r
    |-> ##[1:6] cpu_resume_r) else $error("no resume after wake event");
  resume_run_a: assert property (cpu_resume_r |-> ##[1:2] cpu_clk_en_r)
    else $error("cpu clock off after resume");
  sleep_hold_a: assert property (!sys_clk_en_r |=> $stable(sys_src_r))
    else $error("source changed during sleep");
  sleep_osc_a: assert property (!sys_clk_en_r && !$past(sys_clk_en_r)
    |-> osc_en_r[3] == watchdog_en && osc_en_r[1:0] == 2'b00 && !osc_en_r[4])
    else $error("oscillator left running in sleep");

  // Main scenarios reached
  trap_c: cover property (clk_fail_trap_r);
  sleep_c: cover property (!sys_clk_en_r);
  resume_c: cover property (cpu_resume_r);
endmodule // cspc_checker

bind cspc_top cspc_checker #(.OST_CYC(OST_CYC), .HAND_CYC(HAND_CYC), .RES_CYC(RES_CYC))
  cspc_checker_i (
  .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .switch_monitor_cfg_bit(switch_monitor_cfg_bit), .reset_source_cfg(reset_source_cfg),
  .primary_submode_cfg(primary_submode_cfg), .watchdog_en(watchdog_en),
  .watchdog_timeout(watchdog_timeout), .irq_wake(irq_wake), .ps_req(ps_req),
  .ps_sleep(ps_sleep), .osc_en_r(osc_en_r), .sys_src_r(sys_src_r),
  .primary_submode_r(primary_submode_r), .sys_clk_en_r(sys_clk_en_r),
  .cpu_clk_en_r(cpu_clk_en_r), .cpu_resume_r(cpu_resume_r),
  .watchdog_clr_r(watchdog_clr_r), .clk_fail_trap_r(clk_fail_trap_r));
`default_nettype wire

// ==== sim/cspc_top_test.sv ====
// Purpose: self-checking bench for the clock switch and power save controller
// Assumes: bench drives every input, start-up wait shortened to 4 cycles
// Notes: target oscillator pin runs free at 90 ns
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, a); end end
module cspc_top_test;
  logic        mclk, tclk;
  logic        nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, unlock = 1'b0, cfg_off = 1'b1;
  logic        wd_en = 1'b0, wd_to = 1'b0, irq = 1'b0, ps_req = 1'b0, ps_sleep = 1'b0;
  logic        lock_pin = 1'b0, fail_pin = 1'b0;
  logic [1:0]  addr = 2'h0, wbe = 2'h0, sub_cfg = 2'h2;
  logic [2:0]  rst_src = 3'h2;
  logic [15:0] wdata = 16'h0;
  wire  [15:0] rdata;
  wire  [4:0]  osc_en;
  wire  [2:0]  src, tgt;
  wire  [1:0]  sub;
  wire         sclk_en, cclk_en, resume, trap;
  logic [15:0] rv;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0, n;

  cspc_top #(.OST_CYC(4)) cspc_top_i (
    .mclk(mclk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata), .reg_wbe(wbe),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .unlock(unlock),
    .switch_monitor_cfg_bit(cfg_off), .reset_source_cfg(rst_src), .primary_submode_cfg(sub_cfg),
    .watchdog_en(wd_en), .watchdog_timeout(wd_to), .irq_wake(irq), .ps_req(ps_req),
    .ps_sleep(ps_sleep), .pll_lock_pin(lock_pin), .target_clk_pin(tclk),
    .osc_fail_pin(fail_pin), .osc_en_r(osc_en), .sys_src_r(src), .target_src_r(tgt),
    .primary_submode_r(sub), .sys_clk_en_r(sclk_en), .cpu_clk_en_r(cclk_en),
    .cpu_resume_r(resume), .watchdog_clr_r(), .clk_fail_trap_r(trap));

  // System clock and free-running target oscillator
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    tclk = 1'b0;
    forever #45 tclk = ~tclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic rst(input logic off, input logic [2:0] s, input logic [1:0] sm);
    @(posedge mclk) begin
      nrst <= 1'b0;
      cfg_off <= off;
      rst_src <= s;
      sub_cfg <= sm;
    end
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // Control write, optionally preceded by the unlock pulse
  task automatic wr(input logic u, input logic [1:0] be, input logic [15:0] d);
    @(posedge mclk) unlock <= u;
    @(posedge mclk) begin
      unlock <= 1'b0;
      reg_wr <= 1'b1;
      addr <= 2'h0;
      wbe <= be;
      wdata <= d;
    end
    @(posedge mclk) reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge mclk) begin
      reg_rd <= 1'b1;
      addr <= a;
    end
    @(posedge mclk) reg_rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // Bounded waits on source change and resume pulse
  task automatic wsrc(input logic [2:0] s);
    n = 0;
    while (src !== s && n < 400) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  task automatic wres;
    n = 0;
    while (resume !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask

  // Request a switch and check the busy view
  task automatic sw(input logic [2:0] s);
    wr(1'b1, 2'b10, {5'h0, s, 8'h00});
    wr(1'b1, 2'b01, 16'h0009);
    repeat (3) @(posedge mclk);
    rd(2'h0);
    `CHK("busy", 1'b1, rv[0])
    `CHK("fail_clr", 1'b0, rv[3])
    `CHK("lock_clr", 1'b0, rv[5])
    `CHK("cpu_run", 1'b1, cclk_en)
  endtask

  task automatic fail(input logic [2:0] s);
    @(posedge mclk) fail_pin <= 1'b1;
    n = 0;
    while (trap !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK("trap", 1'b1, trap)
    @(posedge mclk) fail_pin <= 1'b0;
    @(posedge mclk);
    #1 `CHK("fallback", s, src)
    rd(2'h0);
    `CHK("fail_flag", 1'b1, rv[3])
  endtask

  task automatic t_off;
    rd(2'h0);
    `CHK("cur_cfg", 3'h2, rv[14:12])
    wr(1'b1, 2'b10, 16'h0300);
    wr(1'b1, 2'b01, 16'h0001);
    @(posedge mclk) fail_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    fail_pin <= 1'b0;
    rd(2'h0);
    `CHK("req_off", 1'b0, rv[0])
    `CHK("src_off", 3'h2, src)
    `CHK("submode", 2'h2, sub)
    rd(2'h3);
    `CHK("unmapped", 16'h0, rv)
  endtask

  task automatic t_unlock;
    wr(1'b0, 2'b10, 16'h0500);
    rd(2'h0);
    `CHK("no_unlock", 3'h0, rv[10:8])
    wr(1'b1, 2'b10, 16'h0500);
    wr(1'b0, 2'b10, 16'h0400);
    rd(2'h0);
    `CHK("one_write", 3'h5, rv[10:8])
    `CHK("target", 3'h5, tgt)
    wr(1'b1, 2'b10, 16'h0000);
    wr(1'b1, 2'b01, 16'h0001);
    repeat (4) @(posedge mclk);
    rd(2'h0);
    `CHK("redundant", 1'b0, rv[0])
    `CHK("src_kept", 3'h0, src)
  endtask

  task automatic t_switch;
    sw(3'h2);
    wsrc(3'h2);
    `CHK("handover", 1'b1, n >= 33 && n < 400)
    rd(2'h0);
    `CHK("req_done", 1'b0, rv[0])
    `CHK("cur_new", 3'h2, rv[14:12])
    `CHK("osc_en", 5'h0a, osc_en)
    fail(3'h0);
  endtask

  task automatic t_pll;
    sw(3'h3);
    repeat (60) @(posedge mclk);
    lock_pin <= 1'b1;
    #1 `CHK("no_lock", 3'h0, src)
    wsrc(3'h3);
    `CHK("pll_src", 3'h3, src)
    rd(2'h0);
    `CHK("lock_bit", 1'b1, rv[5])
    fail(3'h1);
    wr(1'b1, 2'b01, 16'h0002);
    rd(2'h0);
    `CHK("flag_clr", 1'b0, rv[3])
    `CHK("sosc_bit", 1'b1, rv[1])
    `CHK("sosc_kept", 5'h1d, osc_en)
  endtask

  // Power-save entry, held state and wake
  task automatic t_save(input logic slp);
    @(posedge mclk) begin
      wd_en <= 1'b1;
      ps_req <= 1'b1;
      ps_sleep <= slp;
    end
    @(posedge mclk) ps_req <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK("cpu_off", 1'b0, cclk_en)
    `CHK("sys_clk", !slp, sclk_en)
    `CHK("low_power_rc_osc_on", 1'b1, osc_en[3])
    repeat (20) @(posedge mclk);
    if (slp) begin
      irq <= 1'b1;
    end else begin
      wd_to <= 1'b1;
    end
    wres;
    `CHK("wake_lat", 1'b1, n >= 2 && n <= 5)
    `CHK("same_src", 3'h1, src)
    @(posedge mclk) begin
      irq <= 1'b0;
      wd_to <= 1'b0;
    end
    #1 `CHK("cpu_on", 1'b1, cclk_en)
    `CHK("sys_on", 1'b1, sclk_en)
  endtask

  initial begin
    rst(1'b1, 3'h2, 2'h2);
    t_off;
    rst(1'b0, 3'h0, 2'h1);
    t_unlock;
    t_switch;
    t_pll;
    t_save(1'b1);
    t_save(1'b0);
    print_verdict;
  end
endmodule // cspc_top_test
`default_nettype wire
